// ### mdtf_defs.vh
// constants for the monitor dpll test and input-change flag block
`ifndef MDTF_DEFS_VH
`define MDTF_DEFS_VH
`define MDTF_ADDR_TEST        7'h03
`define MDTF_ADDR_FLAGS       7'h05
`define MDTF_TEST_RESET       8'h14
`define MDTF_FLAGS_RESET      8'hff
`define MDTF_BIT_PHASE_LOST   7
`define MDTF_BIT_FORCE_FULL   6
`define MDTF_BIT_EDGE_SEL     2
`define MDTF_TEST_WMASK       8'h4f
`define MDTF_FLAG_LO          3
`define MDTF_NEAREST_S        2
`define MDTF_CLK_HZ           50000000
`define MDTF_NEAREST_CYC      (`MDTF_NEAREST_S * `MDTF_CLK_HZ)
`endif

// ### mdtf_capture_timer.v
// edge-nearest capture window timer for the monitor dpll
`timescale 1ns/100ps
`include "mdtf_defs.vh"
module mdtf_capture_timer #(
    parameter [31:0] WINDOW_CYC = `MDTF_NEAREST_CYC
) (
    // clock and reset
    input  wire        core_clk,
    input  wire        resetn,
    // control
    input  wire        new_ref,
    input  wire        force_full,
    input  wire        phase_locked,
    // result
    output reg         nearest_only
);
    reg [31:0] count;

    always @(posedge core_clk) begin
        if (!resetn) begin
            count        <= 32'h0000_0000;
            nearest_only <= 1'b0;
        end else if (force_full) begin
            nearest_only <= 1'b0;
            count        <= 32'h0000_0000;
        end else if (new_ref) begin
            nearest_only <= 1'b1;
            count        <= 32'h0000_0000;
        end else if (nearest_only) begin
            if (count >= WINDOW_CYC - 32'h0000_0001) begin
                // stay nearest only if lock was already found
                nearest_only <= phase_locked;
                count        <= 32'h0000_0000;
            end else begin
                count <= count + 32'h0000_0001;
            end
        end
    end
endmodule

// ### mdtf_regs.v
// register bank for monitor dpll test controls and input-change flags
`timescale 1ns/100ps
`include "mdtf_defs.vh"
module mdtf_regs #(
    parameter [31:0] WINDOW_CYC = `MDTF_NEAREST_CYC
) (
    // clock and reset
    input  wire        core_clk,
    input  wire        resetn,
    // host register port
    input  wire [6:0]  reg_addr,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata,
    // monitor dpll status, same clock
    input  wire        mon_phase_lost,
    input  wire        mon_new_ref,
    // reference validity, from pins
    input  wire        ref_input_4,
    input  wire        ref_input_5,
    input  wire        ref_input_6,
    input  wire        ref_input_7,
    input  wire        ref_input_8,
    // monitor dpll controls
    output reg         nearest_only,
    output reg         full_capture,
    output reg         frame_sync_edge_select,
    output reg  [2:0]  test_ctrl
);
    // stored state
    reg  [7:0] test_reg;
    reg  [2:0] low_flags;
    reg  [4:0] valid_s1;
    reg  [4:0] valid_s2;
    reg  [4:0] valid_d;
    reg  [2:0] primed;
    // next values
    reg  [7:0] next_test_reg;
    reg  [2:0] next_low_flags;
    reg  [7:0] next_rdata;
    reg        next_nearest;
    reg        next_full;
    reg        next_edge_sel;
    reg  [2:0] next_test_ctrl;
    // decoded strobes and status
    wire       timer_nearest;
    wire [4:0] valid_in;
    wire [4:0] change;
    wire [4:0] ref_flags;
    wire [7:0] flags;
    wire       wr_test;
    wire       wr_flags;
    wire       rd_test;
    wire       rd_flags;

    function hit;
        input [6:0] a;
        input [6:0] target;
        begin
            hit = (a == target);
        end
    endfunction

    // the stored top bit is never shown; the live lock state replaces it
    function [7:0] test_view;
        input [7:0] stored;
        input       lost;
        begin
            test_view                       = stored;
            test_view[`MDTF_BIT_PHASE_LOST] = lost;
        end
    endfunction

    assign valid_in = {ref_input_8, ref_input_7, ref_input_6, ref_input_5, ref_input_4};
    assign wr_test  = reg_wr && hit(reg_addr, `MDTF_ADDR_TEST);
    assign wr_flags = reg_wr && hit(reg_addr, `MDTF_ADDR_FLAGS);
    assign rd_test  = reg_rd && hit(reg_addr, `MDTF_ADDR_TEST);
    assign rd_flags = reg_rd && hit(reg_addr, `MDTF_ADDR_FLAGS);
    // history trusted only once all three stages hold pin samples
    assign change   = primed[2] ? (valid_s2 ^ valid_d) : 5'h00;
    assign flags    = {ref_flags, low_flags};

    // pins cross two flip-flops before the change detector reads them
    always @(posedge core_clk) begin
        if (!resetn) begin
            valid_s1 <= 5'h00;
            valid_s2 <= 5'h00;
            valid_d  <= 5'h00;
            primed   <= 3'h0;
        end else begin
            valid_s1 <= valid_in;
            valid_s2 <= valid_s1;
            valid_d  <= valid_s2;
            primed   <= {primed[1:0], 1'b1};
        end
    end

    // bits 7, 5 and 4 keep their reset value, so writes to them vanish
    always @* begin
        next_test_reg = test_reg;
        if (wr_test) begin
            next_test_reg = (reg_wdata & `MDTF_TEST_WMASK)
                          | (test_reg & ~`MDTF_TEST_WMASK);
        end
    end

    always @(posedge core_clk) begin
        if (!resetn) begin
            test_reg <= `MDTF_TEST_RESET;
        end else begin
            test_reg <= next_test_reg;
        end
    end

    genvar i;
    generate
        for (i = 0; i < 5; i = i + 1) begin : g_flag
            reg        held;
            reg        next_held;
            always @* begin
                next_held = held;
                if (change[i]) begin
                    // set wins over a clearing write in the same cycle
                    next_held = 1'b1;
                end else if (wr_flags && reg_wdata[`MDTF_FLAG_LO + i]) begin
                    next_held = 1'b0;
                end
            end
            always @(posedge core_clk) begin
                if (!resetn) begin
                    held <= 1'b1;
                end else begin
                    held <= next_held;
                end
            end
            assign ref_flags[i] = held;
        end
    endgenerate

    // inputs 1 to 3 are watched elsewhere; their bits only clear here
    always @* begin
        next_low_flags = low_flags;
        if (wr_flags) begin
            next_low_flags = low_flags & ~reg_wdata[2:0];
        end
    end

    always @(posedge core_clk) begin
        if (!resetn) begin
            low_flags <= 3'h7;
        end else begin
            low_flags <= next_low_flags;
        end
    end

    // a new reference restarts the nearest-edge window unless forced
    mdtf_capture_timer #(
        .WINDOW_CYC   (WINDOW_CYC)
    ) u_timer (
        .core_clk     (core_clk),
        .resetn       (resetn),
        .new_ref      (mon_new_ref),
        .force_full   (test_reg[`MDTF_BIT_FORCE_FULL]),
        .phase_locked (~mon_phase_lost),
        .nearest_only (timer_nearest)
    );

    // read data stands until the next read; unmapped addresses read zero
    // a read never touches the flags
    always @* begin
        next_rdata = reg_rdata;
        if (rd_test) begin
            next_rdata = test_view(test_reg, mon_phase_lost);
        end else if (rd_flags) begin
            next_rdata = flags;
        end else if (reg_rd) begin
            next_rdata = 8'h00;
        end
    end

    always @(posedge core_clk) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    always @* begin
        next_nearest = timer_nearest;
        next_full    = ~timer_nearest;
    end

    always @(posedge core_clk) begin
        if (!resetn) begin
            nearest_only <= 1'b0;
            full_capture <= 1'b0;
        end else begin
            nearest_only <= next_nearest;
            full_capture <= next_full;
        end
    end

    always @* begin
        next_edge_sel  = test_reg[`MDTF_BIT_EDGE_SEL];
        next_test_ctrl = {test_reg[3], test_reg[1], test_reg[0]};
    end

    always @(posedge core_clk) begin
        if (!resetn) begin
            frame_sync_edge_select <= 1'b0;
            test_ctrl              <= 3'h0;
        end else begin
            frame_sync_edge_select <= next_edge_sel;
            test_ctrl              <= next_test_ctrl;
        end
    end
endmodule

// ### mdtf_regs_props.sv
// assertion checker for the monitor test and flag registers
`timescale 1ns/100ps
module mdtf_regs_props #(parameter [31:0] WINDOW_CYC = 20) (
    // watched ports
    input wire       core_clk,
    input wire       resetn,
    input wire [6:0] reg_addr,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire       mon_phase_lost,
    input wire       mon_new_ref,
    input wire       nearest_only,
    input wire       full_capture,
    input wire       frame_sync_edge_select,
    input wire [2:0] test_ctrl
);
    reg  f;
    wire tw = reg_wr && reg_addr == 7'h03;
    wire tr = reg_rd && reg_addr == 7'h03;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // shadow of the force bit, since the test register is not a port
    always @(posedge core_clk) f <= !resetn ? 1'b0 : (tw ? reg_wdata[6] : f);
    property p_win; mon_new_ref && !f |-> ##2 nearest_only[*8]; endproperty
    a_win: assert property (p_win) else $error("window not held");
    property p_end;
        $past(resetn) && $fell(nearest_only) && !f |-> $past(mon_phase_lost, 2);
    endproperty
    a_end: assert property (p_end) else $error("window closed while locked");
    property p_cmp; $past(resetn) |-> full_capture != nearest_only; endproperty
    a_cmp: assert property (p_cmp) else $error("capture outputs agree");
    property p_frc; f && $past(f) && $past(f, 2) |-> !nearest_only; endproperty
    a_frc: assert property (p_frc) else $error("force ignored");
    property p_edg; tw |-> ##2 frame_sync_edge_select == $past(reg_wdata[2], 2); endproperty
    a_edg: assert property (p_edg) else $error("edge select wrong");
    property p_tst;
        tw |-> ##2 test_ctrl == {$past(reg_wdata[3], 2), $past(reg_wdata[1:0], 2)};
    endproperty
    a_tst: assert property (p_tst) else $error("test bits wrong");
    property p_ign; tr |=> reg_rdata[5:4] == 2'b01; endproperty
    a_ign: assert property (p_ign) else $error("unused bits changed");
    property p_lck; tr |=> reg_rdata[7] == $past(mon_phase_lost); endproperty
    a_lck: assert property (p_lck) else $error("lock state wrong");
    c_win: cover property (mon_new_ref && !f);
    c_end: cover property ($fell(nearest_only));
    c_clr: cover property (reg_wr && reg_addr == 7'h05);
endmodule
bind mdtf_regs mdtf_regs_props #(.WINDOW_CYC(WINDOW_CYC)) u_props (.core_clk, .resetn,
    .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .mon_phase_lost, .mon_new_ref,
    .nearest_only, .full_capture, .frame_sync_edge_select, .test_ctrl);

// ### mdtf_tb.sv
// self-checking bench for the monitor test and flag registers
`timescale 1ns/100ps
module tb;
    reg  core_clk, resetn, reg_wr, reg_rd, mon_phase_lost, mon_new_ref;
    reg  [6:0] reg_addr;
    reg  [7:0] reg_wdata;
    reg  [4:0] ref_in;
    wire [7:0] reg_rdata;
    wire [2:0] test_ctrl;
    wire nearest_only, full_capture, frame_sync_edge_select;
    integer n_fail = 0, cmp_count = 0, cyc = 0, i;
    mdtf_regs #(.WINDOW_CYC(20)) dut (.core_clk, .resetn, .reg_addr, .reg_wr, .reg_rd,
        .reg_wdata, .reg_rdata, .mon_phase_lost, .mon_new_ref, .ref_input_4(ref_in[0]),
        .ref_input_5(ref_in[1]), .ref_input_6(ref_in[2]), .ref_input_7(ref_in[3]),
        .ref_input_8(ref_in[4]), .nearest_only, .full_capture, .frame_sync_edge_select,
        .test_ctrl);
    task chk(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask
    task wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge core_clk);
        {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        @(negedge core_clk);
        reg_wr = 0;
    endtask
    // data stands until the next read, so one spare cycle is harmless
    task rd(input logic [6:0] a, input logic [7:0] e);
        @(negedge core_clk);
        {reg_addr, reg_rd} = {a, 1'b1};
        @(negedge core_clk);
        reg_rd = 0;
        @(negedge core_clk);
        chk(reg_rdata, e);
    endtask
    task pulse;
        @(negedge core_clk);
        mon_new_ref = 1;
        @(negedge core_clk);
        mon_new_ref = 0;
        repeat (2) @(negedge core_clk);
    endtask
    task t_regs;
        rd(7'h03, 8'h14);
        rd(7'h05, 8'hff);
        wr(7'h03, 8'h30);
        rd(7'h03, 8'h10);
        chk({4'h0, frame_sync_edge_select, test_ctrl}, 8'h00);
        wr(7'h03, 8'h04);
        @(negedge core_clk);
        chk({4'h0, frame_sync_edge_select, test_ctrl}, 8'h08);
    endtask
    task t_flags;
        wr(7'h05, 8'hff);
        rd(7'h05, 8'h00);
        for (i = 0; i < 5; i++) begin
            ref_in[i] = !ref_in[i];
            repeat (4) @(negedge core_clk);
            rd(7'h05, 8'h08 << i);
            wr(7'h05, 8'h00);
            rd(7'h05, 8'h08 << i);
            wr(7'h05, 8'h08 << i);
            rd(7'h05, 8'h00);
        end
        // pin change and clearing write reach the flag on the same edge
        ref_in[0] = 1'b1;
        @(negedge core_clk);
        wr(7'h05, 8'h08);
        rd(7'h05, 8'h08);
        wr(7'h05, 8'h08);
        rd(7'h05, 8'h00);
    endtask
    task t_cap;
        pulse;
        chk({7'h00, nearest_only}, 8'h01);
        repeat (30) @(negedge core_clk);
        chk({7'h00, nearest_only}, 8'h01);
        mon_phase_lost = 1;
        rd(7'h03, 8'h94);
        pulse;
        repeat (30) @(negedge core_clk);
        chk({6'h00, nearest_only, full_capture}, 8'h01);
        mon_phase_lost = 0;
        wr(7'h03, 8'h44);
        pulse;
        chk({6'h00, nearest_only, full_capture}, 8'h01);
        rd(7'h03, 8'h54);
    endtask
    task end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        core_clk = 0;
        forever #10 core_clk = !core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_fail++;
            end_of_test;
        end
    end
    initial begin
        {resetn, reg_wr, reg_rd, mon_new_ref, mon_phase_lost} = 5'h00;
        {reg_addr, reg_wdata, ref_in} = {7'h00, 8'h00, 5'h1f};
        repeat (6) @(negedge core_clk);
        resetn = 1;
        t_regs;
        t_flags;
        t_cap;
        end_of_test;
    end
endmodule
